/* stf_defines.vh */
// Constants shared by the status transition filter files
`ifndef STF_DEFINES_VH
`define STF_DEFINES_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define STF_W          16
`define STF_NSET       6
`define STF_ALLW       96
`define STF_ZERO       16'h0000
`define STF_ONE_HOT    16'h0001

// ----------------------------------------------------------------------------
// Register set selects
// ----------------------------------------------------------------------------
`define STF_SET_MEAS   3'h0
`define STF_SET_QUES   3'h1
`define STF_SET_OPER   3'h2
`define STF_SET_TRIG   3'h3
`define STF_SET_ARM    3'h4
`define STF_SET_SEQ    3'h5

// ----------------------------------------------------------------------------
// Status command opcodes
// ----------------------------------------------------------------------------
`define STF_OP_WR_RISE 3'h0
`define STF_OP_WR_FALL 3'h1
`define STF_OP_RD_RISE 3'h2
`define STF_OP_RD_FALL 3'h3
`define STF_OP_RD_EVT  3'h4
`define STF_OP_RD_COND 3'h5
`define STF_OP_CLS     3'h6
`define STF_OP_PRESET  3'h7

// ----------------------------------------------------------------------------
// Bit positions of defined events
// ----------------------------------------------------------------------------
`define STF_MEAS_OVF   0
`define STF_MEAS_LOW1  1
`define STF_MEAS_HIGH1 2
`define STF_MEAS_LOW2  3
`define STF_MEAS_HIGH2 4
`define STF_MEAS_RDY   5
`define STF_MEAS_AVAIL 7
`define STF_MEAS_HALF  8
`define STF_MEAS_FULL  9
`define STF_MEAS_PRET  11
`define STF_QUES_TEMP  4
`define STF_QUES_CAL   8
`define STF_QUES_WARN  14
`define STF_OPER_CAL   0
`define STF_OPER_SETL  1
`define STF_OPER_TRIG  5
`define STF_OPER_ARM   6
`define STF_OPER_CALC  9
`define STF_OPER_IDLE  10
`define STF_TRIG_SEQ1  1
`define STF_ARM_SEQ1   1
`define STF_SEQ_ARM_LAYER_ONE   1
`define STF_SEQ_ARM_LAYER_TWO   2

`endif

/* stf_edge.v */
// Per-bit rising and falling change detector on a condition vector
module stf_edge (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // Present condition
  input  wire [15:0] cond,
  // Change pulses
  output wire [15:0] rise,
  output wire [15:0] fall
);

  `include "stf_defines.vh"

  // --------------------------------------------------------------------------
  // Previous value per bit
  // --------------------------------------------------------------------------
  reg [15:0] prev_q;

  genvar b;
  generate
    for (b = 0; b < `STF_W; b = b + 1) begin : g_bit
      always @(posedge ref_clk) begin
        if (!rst_b) begin
          prev_q[b] <= 1'b0;
        end else begin
          prev_q[b] <= cond[b];
        end
      end
      assign rise[b] = cond[b] & ~prev_q[b];
      assign fall[b] = ~cond[b] & prev_q[b];
    end
  endgenerate

endmodule

/* stf_filter.v */
// One register set: condition, rising and falling masks, latched event bits
module stf_filter #(
  parameter [15:0] IMPL = 16'hFFFF
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // Live instrument state
  input  wire [15:0] cond_in,
  // Mask programming
  input  wire        wr_rise,
  input  wire        wr_fall,
  input  wire [15:0] wr_data,
  input  wire        preset,
  // Event clearing
  input  wire        clr_evt,
  // State
  output reg  [15:0] cond_q,
  output reg  [15:0] rise_mask_q,
  output reg  [15:0] fall_mask_q,
  output reg  [15:0] event_q
);

  `include "stf_defines.vh"

  wire [15:0] rise;
  wire [15:0] fall;
  wire [15:0] hit;

  stf_edge u_edge (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .cond    (cond_q),
    .rise    (rise),
    .fall    (fall)
  );

  // Only defined positions can ever latch
  assign hit = ((rise & rise_mask_q) | (fall & fall_mask_q)) & IMPL; // [RULE2] [RULE18] [RULE19]

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cond_q      <= `STF_ZERO;
      rise_mask_q <= IMPL;
      fall_mask_q <= `STF_ZERO; // [RULE3]
      event_q     <= `STF_ZERO;
    end else begin
      cond_q <= cond_in & IMPL; // [RULE20]
      if (preset) begin
        rise_mask_q <= IMPL;      // [RULE21]
        fall_mask_q <= `STF_ZERO; // [RULE3]
      end else begin
        if (wr_rise) begin
          rise_mask_q <= wr_data & IMPL; // [RULE23]
        end
        if (wr_fall) begin
          fall_mask_q <= wr_data & IMPL; // [RULE1] [RULE23]
        end
      end
      // New hits win over a clear in the same cycle
      event_q <= (clr_evt ? `STF_ZERO : event_q) | hit; // [RULE22]
    end
  end

endmodule

/* stf_top.v */
// Status transition filter bank for six status register sets
//
// Behaviour
// RULE1 - Host writes a mask as a binary weight sum; 16384 is bit 14, 0 clears.
// RULE2 - A 1-to-0 condition change with its falling mask bit set latches the event.
// RULE3 - Falling masks are zero after reset and preset; clear-status leaves them.
// RULE4 - A falling mask query returns the value with a one per set bit.
// RULE5 - Measurement bit 0 falls when a reading returns from overflow.
// RULE6 - Measurement bits 1 to 4 fall when a limit test stops failing.
// RULE7 - Measurement bit 5 falls when the next reading starts.
// RULE8 - Measurement bits 7, 8, 9 fall on buffer empty, leaving half, leaving full.
// RULE9 - Measurement pretrigger bit falls when pretrigger operations finish.
// RULE10 - Questionable bit 4 falls when a valid junction reading follows an invalid one.
// RULE11 - Questionable bit 8 falls when a bad calibration constant clears.
// RULE12 - Questionable bit 14 falls when a command parameter runs after one was ignored.
// RULE13 - Operation bits 0, 1, 9 fall at end of calibration, settling, calculation.
// RULE14 - Operation bits 5, 6, 10 fall leaving trigger layer, arm layer, idle.
// RULE15 - Trigger bit 1 falls when the sequence leaves the trigger layer.
// RULE16 - Arm bit 1 falls when the sequence leaves an arm layer.
// RULE17 - Sequence bits 1 and 2 rise while in arm layer one and two.
// RULE18 - A rising mask bit of 1 lets a 0-to-1 change set the event.
// RULE19 - A falling mask bit of 1 lets a 1-to-0 change set the event.
// RULE20 - Condition registers follow the live state and feed the filters.
// RULE21 - Preset sets every defined rising mask bit to one.
// RULE22 - Event bits stay latched until read or cleared.
// RULE23 - Undefined mask positions read zero and ignore writes.
module stf_top (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // Live condition inputs
  input  wire [15:0] meas_cond,
  input  wire [15:0] ques_cond,
  input  wire [15:0] oper_cond,
  input  wire [15:0] trig_cond,
  input  wire [15:0] arm_cond,
  input  wire [15:0] seq_cond,
  // Status command port
  input  wire        cmd_valid,
  input  wire [2:0]  cmd_op,
  input  wire [2:0]  cmd_set,
  input  wire [15:0] decimal_param,
  // Command answer
  output reg         cmd_ack_q,
  output reg         cmd_err_q,
  output reg         rsp_valid_q,
  output reg  [15:0] rsp_data_q,
  // Latched events
  output wire [15:0] meas_event_q,
  output wire [15:0] ques_event_q,
  output wire [15:0] oper_event_q,
  output wire [15:0] trig_event_q,
  output wire [15:0] arm_event_q,
  output wire [15:0] seq_event_q
);

  `include "stf_defines.vh"

  // --------------------------------------------------------------------------
  // Defined event positions per set
  // --------------------------------------------------------------------------
  localparam [15:0] MEAS_IMPL =
    (`STF_ONE_HOT << `STF_MEAS_OVF)   | // [RULE5]
    (`STF_ONE_HOT << `STF_MEAS_LOW1)  | // [RULE6]
    (`STF_ONE_HOT << `STF_MEAS_HIGH1) | // [RULE6]
    (`STF_ONE_HOT << `STF_MEAS_LOW2)  | // [RULE6]
    (`STF_ONE_HOT << `STF_MEAS_HIGH2) | // [RULE6]
    (`STF_ONE_HOT << `STF_MEAS_RDY)   | // [RULE7]
    (`STF_ONE_HOT << `STF_MEAS_AVAIL) | // [RULE8]
    (`STF_ONE_HOT << `STF_MEAS_HALF)  | // [RULE8]
    (`STF_ONE_HOT << `STF_MEAS_FULL)  | // [RULE8]
    (`STF_ONE_HOT << `STF_MEAS_PRET);   // [RULE9]

  localparam [15:0] QUES_IMPL =
    (`STF_ONE_HOT << `STF_QUES_TEMP) | // [RULE10]
    (`STF_ONE_HOT << `STF_QUES_CAL)  | // [RULE11]
    (`STF_ONE_HOT << `STF_QUES_WARN);  // [RULE12]

  localparam [15:0] OPER_IMPL =
    (`STF_ONE_HOT << `STF_OPER_CAL)  | // [RULE13]
    (`STF_ONE_HOT << `STF_OPER_SETL) | // [RULE13]
    (`STF_ONE_HOT << `STF_OPER_CALC) | // [RULE13]
    (`STF_ONE_HOT << `STF_OPER_TRIG) | // [RULE14]
    (`STF_ONE_HOT << `STF_OPER_ARM)  | // [RULE14]
    (`STF_ONE_HOT << `STF_OPER_IDLE);  // [RULE14]

  localparam [15:0] TRIG_IMPL = (`STF_ONE_HOT << `STF_TRIG_SEQ1); // [RULE15]
  localparam [15:0] ARM_IMPL  = (`STF_ONE_HOT << `STF_ARM_SEQ1);  // [RULE16]

  localparam [15:0] SEQ_IMPL =
    (`STF_ONE_HOT << `STF_SEQ_ARM_LAYER_ONE) | // [RULE17]
    (`STF_ONE_HOT << `STF_SEQ_ARM_LAYER_TWO);  // [RULE17]

  localparam [95:0] IMPL_ALL = {SEQ_IMPL, ARM_IMPL, TRIG_IMPL, OPER_IMPL, QUES_IMPL, MEAS_IMPL};

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  wire       set_ok;
  wire       is_global;
  wire       do_cls;
  wire       do_preset;
  wire       is_query;
  wire [5:0] set_hot;

  assign set_ok    = (cmd_set <= `STF_SET_SEQ);
  assign is_global = (cmd_op == `STF_OP_CLS) || (cmd_op == `STF_OP_PRESET);
  assign do_cls    = cmd_valid && (cmd_op == `STF_OP_CLS);
  assign do_preset = cmd_valid && (cmd_op == `STF_OP_PRESET);
  assign is_query  = (cmd_op == `STF_OP_RD_RISE) || (cmd_op == `STF_OP_RD_FALL) ||
                     (cmd_op == `STF_OP_RD_EVT)  || (cmd_op == `STF_OP_RD_COND);

  // Bad set selects touch nothing
  assign set_hot = (cmd_valid && set_ok) ? (6'h01 << cmd_set) : 6'h00;

  // --------------------------------------------------------------------------
  // Filter instances
  // --------------------------------------------------------------------------
  wire [95:0] cond_in_all;
  wire [95:0] cond_all;
  wire [95:0] rise_all;
  wire [95:0] fall_all;
  wire [95:0] event_all;

  assign cond_in_all = {seq_cond, arm_cond, trig_cond, oper_cond, ques_cond, meas_cond};

  genvar s;
  generate
    for (s = 0; s < `STF_NSET; s = s + 1) begin : g_set
      wire wr_rise;
      wire wr_fall;
      wire clr_evt;

      assign wr_rise = set_hot[s] && (cmd_op == `STF_OP_WR_RISE);
      assign wr_fall = set_hot[s] && (cmd_op == `STF_OP_WR_FALL); // [RULE1]
      // Reading an event register empties it; clear-status empties all
      assign clr_evt = do_cls || (set_hot[s] && (cmd_op == `STF_OP_RD_EVT)); // [RULE22] [RULE3]

      stf_filter #(
        .IMPL (IMPL_ALL[s*`STF_W +: `STF_W])
      ) u_filter (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .cond_in     (cond_in_all[s*`STF_W +: `STF_W]),
        .wr_rise     (wr_rise),
        .wr_fall     (wr_fall),
        .wr_data     (decimal_param),
        .preset      (do_preset),
        .clr_evt     (clr_evt),
        .cond_q      (cond_all[s*`STF_W +: `STF_W]),
        .rise_mask_q (rise_all[s*`STF_W +: `STF_W]),
        .fall_mask_q (fall_all[s*`STF_W +: `STF_W]),
        .event_q     (event_all[s*`STF_W +: `STF_W])
      );
    end
  endgenerate

  assign meas_event_q = event_all[15:0];
  assign ques_event_q = event_all[31:16];
  assign oper_event_q = event_all[47:32];
  assign trig_event_q = event_all[63:48];
  assign arm_event_q  = event_all[79:64];
  assign seq_event_q  = event_all[95:80];

  // --------------------------------------------------------------------------
  // Query data select
  // --------------------------------------------------------------------------
  reg [15:0] rd_data;
  reg [15:0] sel_rise;
  reg [15:0] sel_fall;
  reg [15:0] sel_evt;
  reg [15:0] sel_cond;

  always @* begin
    sel_rise = `STF_ZERO;
    sel_fall = `STF_ZERO;
    sel_evt  = `STF_ZERO;
    sel_cond = `STF_ZERO;
    case (cmd_set)
      `STF_SET_MEAS: begin
        sel_rise = rise_all[15:0];
        sel_fall = fall_all[15:0];
        sel_evt  = event_all[15:0];
        sel_cond = cond_all[15:0];
      end
      `STF_SET_QUES: begin
        sel_rise = rise_all[31:16];
        sel_fall = fall_all[31:16];
        sel_evt  = event_all[31:16];
        sel_cond = cond_all[31:16];
      end
      `STF_SET_OPER: begin
        sel_rise = rise_all[47:32];
        sel_fall = fall_all[47:32];
        sel_evt  = event_all[47:32];
        sel_cond = cond_all[47:32];
      end
      `STF_SET_TRIG: begin
        sel_rise = rise_all[63:48];
        sel_fall = fall_all[63:48];
        sel_evt  = event_all[63:48];
        sel_cond = cond_all[63:48];
      end
      `STF_SET_ARM: begin
        sel_rise = rise_all[79:64];
        sel_fall = fall_all[79:64];
        sel_evt  = event_all[79:64];
        sel_cond = cond_all[79:64];
      end
      `STF_SET_SEQ: begin
        sel_rise = rise_all[95:80];
        sel_fall = fall_all[95:80];
        sel_evt  = event_all[95:80];
        sel_cond = cond_all[95:80];
      end
      default: begin
        sel_rise = `STF_ZERO;
      end
    endcase
  end

  always @* begin
    rd_data = `STF_ZERO;
    case (cmd_op)
      `STF_OP_RD_RISE: begin
        rd_data = sel_rise;
      end
      `STF_OP_RD_FALL: begin
        rd_data = sel_fall; // [RULE4]
      end
      `STF_OP_RD_EVT: begin
        rd_data = sel_evt;
      end
      `STF_OP_RD_COND: begin
        rd_data = sel_cond;
      end
      default: begin
        rd_data = `STF_ZERO;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Answer registers
  // --------------------------------------------------------------------------
  // Event reads return the value held before the clear takes effect
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cmd_ack_q   <= 1'b0;
      cmd_err_q   <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= `STF_ZERO;
    end else begin
      cmd_ack_q   <= cmd_valid;
      cmd_err_q   <= cmd_valid && !is_global && !set_ok;
      rsp_valid_q <= cmd_valid && is_query && set_ok;
      if (cmd_valid && is_query && set_ok) begin
        rsp_data_q <= rd_data; // [RULE4]
      end else begin
        rsp_data_q <= `STF_ZERO;
      end
    end
  end

endmodule

/* stf_host.sv */
// Behavioural host that issues status commands and collects the answers
module stf_host (
  // Clock
  input  wire         ref_clk,
  // Command port
  output logic        cmd_valid,
  output logic [2:0]  cmd_op,
  output logic [2:0]  cmd_set,
  output logic [15:0] decimal_param,
  // Answer
  input  wire         cmd_ack_q,
  input  wire         cmd_err_q,
  input  wire         rsp_valid_q,
  input  wire [15:0]  rsp_data_q
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_set = 3'h0;
    decimal_param = 16'h0000;
  end

  // ----------------------------------------------------------------
  // One command per call
  // ----------------------------------------------------------------
  // Weight sum arrives already in binary; conversion stays host side
  task automatic send(input [2:0] op, input [2:0] set, input [15:0] d,
                      output [15:0] r, output [2:0] f);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_set = set;
    decimal_param = d;
    @(negedge ref_clk);
    f = {cmd_ack_q, cmd_err_q, rsp_valid_q};
    r = rsp_data_q;
    cmd_valid = 1'b0;
    // Released qualifiers must not keep showing the last value
    cmd_op = ~op;
    cmd_set = ~set;
    decimal_param = ~d;
  endtask
endmodule

/* stf_top_props.sv */
// Checker for the filter bank command port and latched events
`include "stf_defines.vh"
module stf_props (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst_b,
  // Command port
  input wire        cmd_valid,
  input wire [2:0]  cmd_op,
  input wire [2:0]  cmd_set,
  input wire [15:0] decimal_param,
  // Answer and events
  input wire        cmd_ack_q,
  input wire        cmd_err_q,
  input wire        rsp_valid_q,
  input wire [15:0] rsp_data_q,
  input wire [15:0] meas_event_q,
  input wire [15:0] seq_event_q
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  wire qry = cmd_valid && cmd_op >= `STF_OP_RD_RISE && cmd_op <= `STF_OP_RD_COND;
  wire wr_m = cmd_valid && cmd_op == `STF_OP_WR_FALL && cmd_set == `STF_SET_MEAS;
  wire rd_m = cmd_valid && cmd_op == `STF_OP_RD_FALL && cmd_set == `STF_SET_MEAS;
  wire clr = cmd_valid && (cmd_op == `STF_OP_RD_EVT || cmd_op == `STF_OP_CLS);

  property p_ack; cmd_valid |=> cmd_ack_q; endproperty
  a_ack: assert property (p_ack) else $error("command not acknowledged");
  property p_idle; !cmd_valid |=> !cmd_ack_q && !rsp_valid_q; endproperty
  a_idle: assert property (p_idle) else $error("answer without command");
  property p_err; cmd_valid && cmd_set > `STF_SET_SEQ && cmd_op < `STF_OP_CLS |=> cmd_err_q && !rsp_valid_q; endproperty
  a_err: assert property (p_err) else $error("bad set select not refused");
  property p_rsp; qry && cmd_set <= `STF_SET_SEQ |=> rsp_valid_q && !cmd_err_q; endproperty
  a_rsp: assert property (p_rsp) else $error("query gave no answer");
  property p_zero; !rsp_valid_q |-> rsp_data_q == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("data outside answer");
  property p_wr_rd; wr_m ##1 !cmd_valid ##1 rd_m |=> rsp_data_q == ($past(decimal_param, 3) & 16'h0BBF); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("falling mask readback wrong");
  property p_preset;
    cmd_valid && cmd_op == `STF_OP_PRESET ##1 !cmd_valid ##1 rd_m |=> rsp_data_q == 16'h0000;
  endproperty
  a_preset: assert property (p_preset) else $error("falling mask survived preset");
  property p_hold; !$past(clr) |-> (meas_event_q & $past(meas_event_q)) == $past(meas_event_q); endproperty
  a_hold: assert property (p_hold) else $error("event bit lost without clear");
  property p_undef; (meas_event_q & ~16'h0BBF) == 16'h0000 && (seq_event_q & ~16'h0006) == 16'h0000; endproperty
  a_undef: assert property (p_undef) else $error("event on undefined position");

  c_err: cover property (cmd_err_q);
  c_rsp: cover property (rsp_valid_q && rsp_data_q != 16'h0000);
  c_evt: cover property (meas_event_q != 16'h0000);
endmodule

bind stf_top stf_props u_props (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_set(cmd_set), .decimal_param(decimal_param), .cmd_ack_q(cmd_ack_q), .cmd_err_q(cmd_err_q),
  .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .meas_event_q(meas_event_q), .seq_event_q(seq_event_q));

/* tb_top.sv */
// Self-checking bench for the status transition filter bank
`include "stf_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PAT [6] = '{16'h0BBF, 16'h4110, 16'h0663, 16'h0002, 16'h0002, 16'h0006};
  logic        ref_clk;
  logic        rst_b;
  logic [15:0] cnd [6];
  logic [15:0] r;
  logic [2:0]  f;
  wire         cmd_valid;
  wire  [2:0]  cmd_op;
  wire  [2:0]  cmd_set;
  wire  [15:0] decimal_param;
  wire         cmd_ack_q;
  wire         cmd_err_q;
  wire         rsp_valid_q;
  wire  [15:0] rsp_data_q;
  wire  [15:0] evt [6];
  int          num_errors = 0;
  int          num_checks = 0;

  stf_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .meas_cond(cnd[0]), .ques_cond(cnd[1]), .oper_cond(cnd[2]),
    .trig_cond(cnd[3]), .arm_cond(cnd[4]), .seq_cond(cnd[5]), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_set(cmd_set), .decimal_param(decimal_param), .cmd_ack_q(cmd_ack_q), .cmd_err_q(cmd_err_q),
    .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .meas_event_q(evt[0]), .ques_event_q(evt[1]),
    .oper_event_q(evt[2]), .trig_event_q(evt[3]), .arm_event_q(evt[4]), .seq_event_q(evt[5]));
  stf_host u_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_set(cmd_set),
    .decimal_param(decimal_param), .cmd_ack_q(cmd_ack_q), .cmd_err_q(cmd_err_q),
    .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task chk(input [15:0] g, input [15:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmd(input [2:0] op, input [2:0] s, input [15:0] d);
    u_host.send(op, s, d, r, f);
  endtask
  task wait3;
    repeat (3) @(negedge ref_clk);
  endtask
  task conclude;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    for (int i = 0; i < 6; i++) begin
      cmd(`STF_OP_RD_FALL, i[2:0], 16'h0000);
      chk(r, 16'h0000);
      cmd(`STF_OP_RD_RISE, i[2:0], 16'h0000);
      chk(r, PAT[i]);
    end
    $display("test reset done");
  endtask
  task t_masks;
    cmd(`STF_OP_WR_FALL, `STF_SET_QUES, 16'h4000);
    cmd(`STF_OP_RD_FALL, `STF_SET_QUES, 16'h0000);
    chk(r, 16'h4000);
    cmd(`STF_OP_WR_FALL, `STF_SET_OPER, 16'h0402);
    cmd(`STF_OP_RD_FALL, `STF_SET_OPER, 16'h0000);
    chk(r, 16'h0402);
    cmd(`STF_OP_WR_FALL, `STF_SET_MEAS, 16'hFFFF);
    cmd(`STF_OP_RD_FALL, `STF_SET_MEAS, 16'h0000);
    chk(r, PAT[0]);
    cmd(`STF_OP_WR_FALL, `STF_SET_MEAS, 16'h0000);
    cmd(`STF_OP_RD_FALL, `STF_SET_MEAS, 16'h0000);
    chk(r, 16'h0000);
    cmd(`STF_OP_RD_FALL, 3'h6, 16'h0000);
    chk({13'h0000, f}, 16'h0006);
    $display("test masks done");
  endtask
  task t_edges;
    for (int i = 0; i < 6; i++) begin
      cmd(`STF_OP_WR_RISE, i[2:0], 16'h0000);
      cmd(`STF_OP_WR_FALL, i[2:0], 16'hFFFF);
      cnd[i] = 16'hFFFF;
      wait3;
      chk(evt[i], 16'h0000);
      cmd(`STF_OP_RD_COND, i[2:0], 16'h0000);
      chk(r, PAT[i]);
      cnd[i] = 16'h0000;
      wait3;
      chk(evt[i], PAT[i]);
      cnd[i] = 16'hFFFF;
      wait3;
      chk(evt[i], PAT[i]);
      cmd(`STF_OP_RD_EVT, i[2:0], 16'h0000);
      chk(r, PAT[i]);
      chk(evt[i], 16'h0000);
      cmd(`STF_OP_WR_RISE, i[2:0], 16'hFFFF);
      cmd(`STF_OP_WR_FALL, i[2:0], 16'h0000);
      cnd[i] = 16'h0000;
      wait3;
      chk(evt[i], 16'h0000);
      cnd[i] = 16'hFFFF;
      wait3;
      chk(evt[i], PAT[i]);
      cnd[i] = 16'h0000;
      cmd(`STF_OP_RD_EVT, i[2:0], 16'h0000);
    end
    $display("test edges done");
  endtask
  task t_cls_preset;
    // Rising masks cleared first so that preset has something to restore
    for (int i = 0; i < 6; i++) begin
      cmd(`STF_OP_WR_FALL, i[2:0], 16'hFFFF);
      cmd(`STF_OP_WR_RISE, i[2:0], 16'h0000);
    end
    cnd[0] = 16'hFFFF;
    wait3;
    chk(evt[0], 16'h0000);
    cnd[0] = 16'h0000;
    wait3;
    chk(evt[0], PAT[0]);
    cmd(`STF_OP_CLS, 3'h0, 16'h0000);
    chk(evt[0], 16'h0000);
    for (int i = 0; i < 6; i++) begin
      cmd(`STF_OP_RD_FALL, i[2:0], 16'h0000);
      chk(r, PAT[i]);
    end
    cmd(`STF_OP_PRESET, 3'h0, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      cmd(`STF_OP_RD_FALL, i[2:0], 16'h0000);
      chk(r, 16'h0000);
      cmd(`STF_OP_RD_RISE, i[2:0], 16'h0000);
      chk(r, PAT[i]);
    end
    $display("test clear and preset done");
  endtask
  task t_mid_reset;
    cmd(`STF_OP_WR_FALL, `STF_SET_OPER, 16'hFFFF);
    cmd(`STF_OP_WR_RISE, `STF_SET_OPER, 16'h0000);
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    cmd(`STF_OP_RD_FALL, `STF_SET_OPER, 16'h0000);
    chk(r, 16'h0000);
    cmd(`STF_OP_RD_RISE, `STF_SET_OPER, 16'h0000);
    chk(r, PAT[2]);
    $display("test mid reset done");
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    rst_b = 1'b0;
    for (int i = 0; i < 6; i++) cnd[i] = 16'h0000;
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset;
    t_masks;
    t_edges;
    t_cls_preset;
    t_mid_reset;
    conclude;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    conclude;
  end
endmodule
